// ===== rtl/otppc_defines.svh
// Constants for the programming-mode control block.
`ifndef OTPPC_DEFINES_SVH
`define OTPPC_DEFINES_SVH
`define OTPPC_MAIN_PGM_ADDR   7'h20
`define OTPPC_SAFE_PGM_ADDR   7'h21
`define OTPPC_MAIN_ADDR_RST   7'h20
`define OTPPC_SAFE_ADDR_RST   7'h21
`define OTPPC_BURN_TIME_NS    4000
`define OTPPC_CLK_PERIOD_NS   40
`define OTPPC_BURN_CYCLES     \
  ((`OTPPC_BURN_TIME_NS + `OTPPC_CLK_PERIOD_NS - 1) / `OTPPC_CLK_PERIOD_NS)
`define OTPPC_SECT_PRIMARY    1'b0
`define OTPPC_SECT_SPARE      1'b1
`define OTPPC_MAX_BURNS       2
`endif

// ===== rtl/otppc_pkg.sv
// Types shared by the programming-mode control block.
package otppc_pkg;
  typedef enum logic [2:0] {
    OTPPC_ST_RESET,
    OTPPC_ST_PGM_MODE,
    OTPPC_ST_BURN,
    OTPPC_ST_BOOT,
    OTPPC_ST_RUN
  } otppc_state_t;
  typedef struct packed {
    logic crc;
    logic boot_enable_flag;
    logic write_protect;
    logic burn_count_index;
  } otppc_sector_t;
endpackage : otppc_pkg

// ===== rtl/otppc_fuse_store.sv
// Small fuse store: one burned address word per sector, registered read data.
`timescale 1ns/1ps
`default_nettype none
module otppc_fuse_store #(
  parameter int AW = 7
) (
  input  wire logic          clk,     // System clock.
  input  wire logic          rst_b,   // Asynchronous reset, active low.
  input  wire logic          ce,      // Clock enable.
  input  wire logic          wr_en,   // Burn strobe.
  input  wire logic          wr_sel,  // Sector to burn.
  input  wire logic [2*AW-1:0] wr_data, // Main and safety addresses to burn.
  input  wire logic          rd_sel,  // Sector to read.
  output logic [2*AW-1:0]    rd_data  // Registered read data.
);
  logic [2*AW-1:0] mem_reg [2];
  logic [2*AW-1:0] mem_next [2];
  logic [2*AW-1:0] rd_next;

  // Write port and read mux; a burned word changes only on a burn strobe or a reset.
  always_comb begin
    mem_next = mem_reg;
    if (wr_en) begin
      mem_next[wr_sel] = wr_data;
    end
    rd_next = mem_reg[rd_sel];
  end

  // Contents model fuses, so they clear only at power-on reset.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mem_reg[0] <= '0;
      mem_reg[1] <= '0;
      rd_data    <= '0;
    end else if (ce) begin
      mem_reg <= mem_next;
      rd_data <= rd_next;
    end
  end
endmodule : otppc_fuse_store
`default_nettype wire

// ===== rtl/otppc_ctrl.sv
// Programming-mode control: entry, exit, addresses, burn flags and status.
`timescale 1ns/1ps
`default_nettype none
`include "otppc_defines.svh"
module otppc_ctrl #(
  parameter int AW          = 7,
  parameter int BURN_CYCLES = `OTPPC_BURN_CYCLES
) (
  input  wire logic                    clk,              // 25 MHz clock.
  input  wire logic                    rst_b,            // Async reset, active low.
  input  wire logic                    ce,               // Clock enable.
  input  wire logic                    dbg_pgm_level,    // Debug pin at programming voltage.
  input  wire logic                    dbg_above_exit,   // Debug pin above exit threshold.
  input  wire logic                    main_exit_cmd,    // Exit command, main machine.
  input  wire logic                    safe_exit_cmd,    // Exit command, safety machine.
  input  wire logic                    test_mode,        // Test mode active.
  input  wire logic                    mirror_wr,        // Mirror address write strobe.
  input  wire logic [AW-1:0]           mirror_main_wdata,// New main address.
  input  wire logic [AW-1:0]           mirror_safe_wdata,// New safety address.
  input  wire logic                    mirrors_filled,   // Mirrors hold a configuration.
  input  wire logic                    burn_cmd,         // Fuse programming command.
  output logic                         main_pgm_mode,    // Main machine halted in mode.
  output logic                         safe_pgm_mode,    // Safety machine halted in mode.
  output logic [AW-1:0]                main_addr,        // Main I2C address.
  output logic [AW-1:0]                safe_addr,        // Safety I2C address.
  output otppc_pkg::otppc_sector_t     sect_primary,     // Primary sector flags.
  output otppc_pkg::otppc_sector_t     sect_spare,       // Spare sector flags.
  output logic [7:0]                   main_status,      // Main programming status.
  output logic [7:0]                   safe_status       // Safety programming status.
);
  import otppc_pkg::*;

  // Values the logic cannot serve are refused while the design is elaborated.
  if (AW != 7) begin : g_bad_aw
    $error("Address width must be 7.");
  end
  if (BURN_CYCLES < 1) begin : g_bad_burn
    $error("Burn time must be at least one cycle.");
  end

  localparam int CW = $clog2(BURN_CYCLES + 1);

  // Status bit positions: busy, error, single, double, limit, protect, boot err, done.
  function automatic logic [7:0] status_word(input logic busy, input logic err,
                                             input logic lim, input logic wpf,
                                             input logic done);
    status_word = {done, 1'b0, wpf, lim, 1'b0, 1'b0, err, busy};
  endfunction : status_word

  otppc_state_t    main_st_reg, main_st_next;
  otppc_state_t    safe_st_reg, safe_st_next;
  logic [AW-1:0]   mir_main_reg, mir_main_next;
  logic [AW-1:0]   mir_safe_reg, mir_safe_next;
  logic [1:0]      burns_reg, burns_next;
  logic [CW-1:0]   cnt_reg, cnt_next;
  logic            err_reg, err_next;
  logic            lim_reg, lim_next;
  logic            wpf_reg, wpf_next;
  logic            burn_sel_reg, burn_sel_next;
  logic            burn_wr;
  logic [2*AW-1:0] fuse_rd;
  logic            fuse_valid;

  assign fuse_valid = (burns_reg != 2'h0);

  // Burned words live in a separate store so the read path is registered.
  otppc_fuse_store #(.AW(AW)) u_fuse (
    .clk     (clk),
    .rst_b   (rst_b),
    .ce      (ce),
    .wr_en   (burn_wr),
    .wr_sel  (burn_sel_reg),
    .wr_data ({mir_main_reg, mir_safe_reg}),
    .rd_sel  (burns_reg == 2'h2),
    .rd_data (fuse_rd)
  );

  // Machine sequencing; both machines share entry, each has its own exit command.
  always_comb begin
    main_st_next  = main_st_reg;
    safe_st_next  = safe_st_reg;
    cnt_next      = cnt_reg;
    burns_next    = burns_reg;
    err_next      = err_reg;
    lim_next      = lim_reg;
    wpf_next      = wpf_reg;
    burn_sel_next = burn_sel_reg;
    burn_wr       = 1'b0;
    mir_main_next = mir_main_reg;
    mir_safe_next = mir_safe_reg;
    case (main_st_reg)
      OTPPC_ST_RESET: begin
        if (dbg_pgm_level) begin
          main_st_next = OTPPC_ST_PGM_MODE;
          safe_st_next = OTPPC_ST_PGM_MODE;
        end else begin
          main_st_next = OTPPC_ST_BOOT;
          safe_st_next = OTPPC_ST_BOOT;
        end
      end
      OTPPC_ST_PGM_MODE: begin
        if (burn_cmd) begin
          // Burning needs test mode and full voltage; a full store refuses.
          if (!test_mode || !dbg_pgm_level) begin
            err_next = 1'b1;
          end else if (burns_reg == 2'(`OTPPC_MAX_BURNS)) begin
            lim_next = 1'b1;
            wpf_next = 1'b1;
          end else begin
            main_st_next  = OTPPC_ST_BURN;
            burn_sel_next = (burns_reg == 2'h0) ? `OTPPC_SECT_PRIMARY : `OTPPC_SECT_SPARE;
            cnt_next      = CW'(BURN_CYCLES);
            err_next      = 1'b0;
          end
        end else if (!dbg_above_exit || main_exit_cmd) begin
          main_st_next = OTPPC_ST_BOOT;
        end
      end
      OTPPC_ST_BURN: begin
        if (cnt_reg == CW'(1)) begin
          burn_wr      = 1'b1;
          burns_next   = burns_reg + 2'h1;
          main_st_next = OTPPC_ST_PGM_MODE;
        end
        cnt_next = cnt_reg - CW'(1);
      end
      OTPPC_ST_BOOT: begin
        main_st_next = OTPPC_ST_RUN;
      end
      OTPPC_ST_RUN: begin
        main_st_next = OTPPC_ST_RUN;
      end
      default: main_st_next = OTPPC_ST_RESET;
    endcase
    // The safety machine leaves on its own command or a dropped pin.
    if (safe_st_reg == OTPPC_ST_PGM_MODE && main_st_reg != OTPPC_ST_RESET &&
        (!dbg_above_exit || safe_exit_cmd)) begin
      safe_st_next = OTPPC_ST_BOOT;
    end else if (safe_st_reg == OTPPC_ST_BOOT) begin
      safe_st_next = OTPPC_ST_RUN;
    end
    // Boot loads the burned word into the mirrors when one exists.
    if (main_st_reg == OTPPC_ST_BOOT && fuse_valid) begin
      mir_main_next = fuse_rd[2*AW-1:AW];
      mir_safe_next = fuse_rd[AW-1:0];
    end else if (mirror_wr && test_mode) begin
      mir_main_next = mirror_main_wdata;
      mir_safe_next = mirror_safe_wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      main_st_reg  <= OTPPC_ST_RESET;
      safe_st_reg  <= OTPPC_ST_RESET;
      cnt_reg      <= '0;
      burns_reg    <= 2'h0;
      err_reg      <= 1'b0;
      lim_reg      <= 1'b0;
      wpf_reg      <= 1'b0;
      burn_sel_reg <= 1'b0;
      mir_main_reg <= `OTPPC_MAIN_ADDR_RST;
      mir_safe_reg <= `OTPPC_SAFE_ADDR_RST;
    end else if (ce) begin
      main_st_reg  <= main_st_next;
      safe_st_reg  <= safe_st_next;
      cnt_reg      <= cnt_next;
      burns_reg    <= burns_next;
      err_reg      <= err_next;
      lim_reg      <= lim_next;
      wpf_reg      <= wpf_next;
      burn_sel_reg <= burn_sel_next;
      mir_main_reg <= mir_main_next;
      mir_safe_reg <= mir_safe_next;
    end
  end

  // Registered outputs; addresses are fixed only while halted in mode.
  logic             main_pm_next, safe_pm_next;
  logic [AW-1:0]    main_addr_next, safe_addr_next;
  otppc_sector_t    prim_next, spare_next;
  logic [7:0]       main_stat_next, safe_stat_next;

  always_comb begin
    main_pm_next   = (main_st_next == OTPPC_ST_PGM_MODE) || (main_st_next == OTPPC_ST_BURN);
    safe_pm_next   = (safe_st_next == OTPPC_ST_PGM_MODE);
    main_addr_next = main_pm_next ? `OTPPC_MAIN_PGM_ADDR : mir_main_next;
    safe_addr_next = safe_pm_next ? `OTPPC_SAFE_PGM_ADDR : mir_safe_next;
    // Primary sector: index always set; checksum follows mirrors until burned.
    prim_next.burn_count_index = 1'b1;
    prim_next.crc              = mirrors_filled || (burns_next != 2'h0);
    prim_next.boot_enable_flag = (burns_next != 2'h0);
    prim_next.write_protect    = (burns_next != 2'h0);
    spare_next.burn_count_index = (burns_next == 2'h2);
    spare_next.crc              = mirrors_filled || (burns_next == 2'h2);
    spare_next.boot_enable_flag = (burns_next == 2'h2);
    spare_next.write_protect    = (burns_next == 2'h2);
    main_stat_next = status_word(main_st_next == OTPPC_ST_BURN, err_next, lim_next,
                                 wpf_next, main_st_next == OTPPC_ST_RUN);
    safe_stat_next = status_word(1'b0, 1'b0, 1'b0, 1'b0,
                                 safe_st_next == OTPPC_ST_RUN);
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      main_pgm_mode <= 1'b0;
      safe_pgm_mode <= 1'b0;
      main_addr     <= `OTPPC_MAIN_ADDR_RST;
      safe_addr     <= `OTPPC_SAFE_ADDR_RST;
      sect_primary  <= '0;
      sect_spare    <= '0;
      main_status   <= 8'h00;
      safe_status   <= 8'h00;
    end else if (ce) begin
      main_pgm_mode <= main_pm_next;
      safe_pgm_mode <= safe_pm_next;
      main_addr     <= main_addr_next;
      safe_addr     <= safe_addr_next;
      sect_primary  <= prim_next;
      sect_spare    <= spare_next;
      main_status   <= main_stat_next;
      safe_status   <= safe_stat_next;
    end
  end
endmodule : otppc_ctrl
`default_nettype wire

// ===== verif/otppc_ctrl_properties.sv
// Concurrent checks on the ports of the programming-mode control block.
`timescale 1ns/1ps
`default_nettype none
`include "otppc_defines.svh"
module otppc_ctrl_properties
  import otppc_pkg::*;
#(
  parameter int AW          = 7,
  parameter int BURN_CYCLES = 2
) (
  input wire logic            clk,            // Clock.
  input wire logic            rst_b,          // Reset, active low.
  input wire logic            ce,             // Clock enable.
  input wire logic            dbg_pgm_level,  // Full voltage.
  input wire logic            dbg_above_exit, // Above exit level.
  input wire logic            main_exit_cmd,  // Main exit.
  input wire logic            test_mode,      // Test mode.
  input wire logic            mirror_wr,      // Mirror write.
  input wire logic            mirrors_filled, // Mirrors loaded.
  input wire logic            burn_cmd,       // Burn request.
  input wire logic            main_pgm_mode,  // Main halted.
  input wire logic            safe_pgm_mode,  // Safety halted.
  input wire logic [AW-1:0]   main_addr,      // Main address.
  input wire otppc_sector_t   sect_primary,   // Primary flags.
  input wire otppc_sector_t   sect_spare,     // Spare flags.
  input wire logic [7:0]      main_status     // Main status.
);
  logic [15:0] busy_cnt_reg;
  logic [15:0] busy_cnt_next;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // A counter checks the burn length, since a long repetition would slow the tools.
  always_comb begin
    busy_cnt_next = main_status[0] ? busy_cnt_reg + 16'h1 : 16'h0;
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) busy_cnt_reg <= 16'h0;
    else busy_cnt_reg <= busy_cnt_next;
  end
  // Properties tie an output to the input or output that caused it, with the exact cycle; a_status_zero holds always.
  a_entry_halts: assert property (!$past(rst_b) && ce && dbg_pgm_level
    |=> main_pgm_mode && safe_pgm_mode)
    else $error("programming mode not entered");
  a_mode_addr: assert property (main_pgm_mode |-> main_addr == `OTPPC_MAIN_PGM_ADDR)
    else $error("main address wrong in programming mode");
  a_exit_pin: assert property (safe_pgm_mode && ce && !dbg_above_exit
    && !burn_cmd && !main_status[0] |=> !safe_pgm_mode)
    else $error("low pin did not end programming mode");
  a_exit_cmd: assert property (main_pgm_mode && ce && main_exit_cmd
    && !burn_cmd && !main_status[0] |=> !main_pgm_mode ##1 main_status[7])
    else $error("exit command did not start the main machine");
  a_mirror_hold: assert property (main_status[7] && ce && !test_mode && mirror_wr
    |=> $stable(main_addr))
    else $error("mirror address changed outside test mode");
  a_burn_refused: assert property (main_pgm_mode && ce && burn_cmd && !main_status[0]
    && !(test_mode && dbg_pgm_level) |=> main_status[1] && !main_status[0])
    else $error("burn accepted without test mode or voltage");
  a_burn_first: assert property ($fell(main_status[0])
    |-> sect_primary == 4'hf && busy_cnt_reg == BURN_CYCLES)
    else $error("primary flags or burn length wrong");
  a_unburned_flags: assert property ($past(rst_b) && !sect_primary.write_protect
    |-> sect_primary.burn_count_index && !sect_primary.boot_enable_flag
    && sect_primary.crc == $past(mirrors_filled))
    else $error("unburned primary flags wrong");
  a_burn_second: assert property ($fell(main_status[0])
    && $past(sect_primary.write_protect) |-> sect_spare == 4'hf)
    else $error("spare flags wrong after second burn");
  // A low clock enable must freeze main_addr, main_status and sect_primary for that cycle.
  a_ce_freeze: assert property (!ce |=> $stable(main_addr) && $stable(main_status)
    && $stable(sect_primary))
    else $error("outputs moved while the clock enable was low");
  a_status_zero: assert property (main_status[3:2] == 2'h0 && !main_status[6])
    else $error("unused status bits set");
  c_burn: cover property ($fell(main_status[0]));
  c_exit: cover property ($fell(main_pgm_mode));
  c_limit: cover property (main_status[5:4] == 2'h3);
endmodule : otppc_ctrl_properties
bind otppc_ctrl otppc_ctrl_properties #(.AW(AW), .BURN_CYCLES(BURN_CYCLES)) u_props (
  .clk, .rst_b, .ce, .dbg_pgm_level, .dbg_above_exit, .main_exit_cmd, .test_mode, .mirror_wr,
  .mirrors_filled, .burn_cmd, .main_pgm_mode, .safe_pgm_mode, .main_addr, .sect_primary,
  .sect_spare, .main_status);
`default_nettype wire

// ===== verif/otppc_host_model.sv
// Host programmer model that issues burn and exit commands to the block.
`timescale 1ns/1ps
`default_nettype none
module otppc_host_model (
  input  wire logic test_mode,     // Test mode active.
  input  wire logic dbg_pgm_level, // Full voltage on pin.
  input  wire logic req_burn,      // Bench asks for a burn.
  input  wire logic force_burn,    // Burn despite the checks.
  input  wire logic req_main_exit, // Bench asks main exit.
  input  wire logic req_safe_exit, // Bench asks safety exit.
  output logic      burn_cmd,      // Burn command.
  output logic      main_exit_cmd, // Main exit command.
  output logic      safe_exit_cmd  // Safety exit command.
);
  // A careful host burns only in test mode at full voltage; force_burn breaks that on purpose.
  assign burn_cmd = req_burn && (force_burn || (test_mode && dbg_pgm_level));
  assign main_exit_cmd = req_main_exit;
  assign safe_exit_cmd = req_safe_exit;
endmodule : otppc_host_model
`default_nettype wire

// ===== verif/tb_top.sv
// Self-checking bench for the programming-mode control block.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import otppc_pkg::*;
  typedef struct {int sel; logic [7:0] mask; logic [7:0] val;} otppc_note_t;
  logic clk = 1'b0, rst_b = 1'b0, ce = 1'b1, dbg_pgm_level = 1'b1, dbg_above_exit = 1'b1;
  logic test_mode = 1'b0, mirror_wr = 1'b0, mirrors_filled = 1'b0, req_burn = 1'b0;
  logic force_burn = 1'b0, req_main_exit = 1'b0, req_safe_exit = 1'b0;
  logic burn_cmd, main_exit_cmd, safe_exit_cmd, main_pgm_mode, safe_pgm_mode;
  logic [6:0] mirror_main_wdata = 7'h00, mirror_safe_wdata = 7'h00, main_addr, safe_addr, md, sd;
  otppc_sector_t sect_primary, sect_spare;
  logic [7:0] main_status, safe_status;
  otppc_note_t notes[$];
  otppc_note_t cur;
  int miscompares = 0, n_compared = 0, cycles = 0;
  string names[7] = '{"modes", "main_addr", "safe_addr", "primary", "spare", "status",
                      "safe_status"};
  always #20 clk = ~clk;
  otppc_host_model u_host (.test_mode, .dbg_pgm_level, .req_burn, .force_burn, .req_main_exit,
    .req_safe_exit, .burn_cmd, .main_exit_cmd, .safe_exit_cmd);
  otppc_ctrl #(.AW(7), .BURN_CYCLES(2)) u_dut (.clk, .rst_b, .ce, .dbg_pgm_level, .dbg_above_exit,
    .main_exit_cmd, .safe_exit_cmd, .test_mode, .mirror_wr, .mirror_main_wdata,
    .mirror_safe_wdata, .mirrors_filled, .burn_cmd, .main_pgm_mode, .safe_pgm_mode, .main_addr,
    .safe_addr, .sect_primary, .sect_spare, .main_status, .safe_status);
  function automatic logic [7:0] obs(input int sel);
    case (sel)
      0: return {6'h00, main_pgm_mode, safe_pgm_mode};
      1: return {1'b0, main_addr};
      2: return {1'b0, safe_addr};
      3: return {4'h0, sect_primary};
      4: return {4'h0, sect_spare};
      5: return main_status;
      default: return safe_status;
    endcase
  endfunction : obs
  task automatic check(input logic [7:0] seen, input logic [7:0] expv, input string what);
    n_compared++;
    if (seen !== expv) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, expv, seen);
    end
  endtask : check
  task automatic note(input int sel, input logic [7:0] mask, input logic [7:0] val);
    notes.push_back('{sel, mask, val});
  endtask : note
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : conclude
  // Notes made at a falling edge are judged just after the next rising edge has landed.
  always @(posedge clk) begin
    #1;
    while (notes.size() > 0) begin
      cur = notes.pop_front();
      check(obs(cur.sel) & cur.mask, cur.val & cur.mask, names[cur.sel]);
    end
  end
  // A hang is cut short well after the 25 or so cycles the sequence needs.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      miscompares++;
      conclude();
    end
  end
  // Inputs change only at falling edges, together with the results they should cause.
  initial begin
    void'($urandom(57668));
    md = 7'($urandom);
    sd = 7'($urandom);
    repeat (3) @(negedge clk);
    rst_b = 1'b1;
    @(negedge clk);
    note(0, 8'h03, 8'h03);
    note(1, 8'h7f, 8'h20);
    note(2, 8'h7f, 8'h21);
    note(3, 8'h0f, 8'h01);
    note(4, 8'h0f, 8'h00);
    @(negedge clk);
    mirrors_filled = 1'b1;
    note(3, 8'h0f, 8'h09);
    note(4, 8'h0f, 8'h08);
    @(negedge clk);
    mirror_main_wdata = ~md;
    mirror_wr = 1'b1;
    req_burn = 1'b1;
    force_burn = 1'b1;
    note(5, 8'h03, 8'h02);
    @(negedge clk);
    mirror_main_wdata = md;
    mirror_safe_wdata = sd;
    test_mode = 1'b1;
    req_burn = 1'b0;
    force_burn = 1'b0;
    note(1, 8'h7f, 8'h20);
    for (int b = 0; b < 3; b++) begin
      @(negedge clk);
      mirror_wr = 1'b0;
      req_burn = 1'b1;
      note(5, 8'h31, (b < 2) ? 8'h01 : 8'h30);
      @(negedge clk);
      req_burn = 1'b0;
      for (int w = 0; w < 10 && main_status[0] === 1'b1; w++) @(negedge clk);
      if (b < 2) note(3 + b, 8'h0f, 8'h0f);
    end
    @(negedge clk);
    // New mirror values in test mode differ from the burned word, so the boot load shows.
    req_main_exit = 1'b1;
    mirror_wr = 1'b1;
    mirror_main_wdata = ~md;
    mirror_safe_wdata = ~sd;
    note(0, 8'h03, 8'h01);
    note(1, 8'h7f, {1'b0, ~md});
    @(negedge clk);
    req_main_exit = 1'b0;
    test_mode = 1'b0;
    mirror_wr = 1'b1;
    mirror_main_wdata = ~md;
    note(1, 8'h7f, {1'b0, md});
    @(negedge clk);
    dbg_above_exit = 1'b0;
    dbg_pgm_level = 1'b0;
    note(0, 8'h03, 8'h00);
    note(2, 8'h7f, {1'b0, sd});
    note(5, 8'h80, 8'h80);
    @(negedge clk);
    mirror_wr = 1'b0;
    note(1, 8'h7f, {1'b0, md});
    note(6, 8'h80, 8'h80);
    // With the clock enable low a legal mirror write must not land.
    @(negedge clk);
    ce = 1'b0;
    test_mode = 1'b1;
    mirror_wr = 1'b1;
    note(1, 8'h7f, {1'b0, md});
    @(negedge clk);
    ce = 1'b1;
    test_mode = 1'b0;
    mirror_wr = 1'b0;
    note(1, 8'h7f, {1'b0, md});
    repeat (2) @(negedge clk);
    conclude();
  end
endmodule : tb_top
`default_nettype wire
